// *** rtl/wdog_pkg.sv ***
// package: watchdog and reset-source constants, register map and types
package wdog_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TCL_PS = CLK_PERIOD_PS / 2;
  localparam int MIN_PULSE_NS = 500;
  localparam int MIN_PULSE_TCL = 4;
  localparam int LONG_SEQ_TCL = 1032 + 12;
  localparam int WD_SEQ_TCL = 1024;
  localparam int MIN_PULSE_PS_A = MIN_PULSE_NS * 1000;
  localparam int MIN_PULSE_PS_B = MIN_PULSE_TCL * TCL_PS;
  localparam int MIN_PULSE_PS = (MIN_PULSE_PS_A > MIN_PULSE_PS_B) ? MIN_PULSE_PS_A : MIN_PULSE_PS_B;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LONG_SEQ_CYC = (LONG_SEQ_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WD_SEQ_CYC = (WD_SEQ_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEQ_W = 11;
  // ----------------------------------------------------------------
  // counter and prescaler
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int RELOAD_W = 8;
  localparam int DIV_SLOW = 128;
  localparam int DIV_FAST = 2;
  localparam int PRE_W = 7;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
  // control register fields
  localparam int CTRL_PSEL_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_FLAGS_LSB = 2;
  localparam int CTRL_END_OF_INIT_INSTRUCTION_BIT = 7;
  localparam int CTRL_RELOAD_LSB = 8;
  // command register bits
  localparam int CMD_SERVICE_BIT = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int CMD_END_OF_INIT_INSTRUCTION_BIT = 2;
  localparam int CMD_SWRST_BIT = 3;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_HWRST_BIT = 2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_on_flag;
    logic long_hw_reset_flag;
    logic short_hw_reset_flag;
    logic wdog_reset_flag;
    logic sw_reset_flag;
  } reset_flags_s;
  localparam reset_flags_s FLAGS_POR = '{power_on_flag: 1'b1, default: 1'b0};
  localparam reset_flags_s FLAGS_NONE = '0;
  typedef enum logic [1:0] {ST_RUN, ST_HW_SEQ, ST_HOLD, ST_WD_SEQ} rst_state_e;
endpackage

// *** rtl/wdog_prescaler.sv ***
// module: watchdog prescaler, one tick every 2 or 128 clocks
`timescale 1ns/1ps
module wdog_prescaler #(
  parameter int DIV_FAST = wdog_pkg::DIV_FAST,
  parameter int DIV_SLOW = wdog_pkg::DIV_SLOW
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic div_sel_in,
  output logic tick_out
);
  localparam logic [wdog_pkg::PRE_W-1:0] LAST_FAST = wdog_pkg::PRE_W'(DIV_FAST - 1);
  localparam logic [wdog_pkg::PRE_W-1:0] LAST_SLOW = wdog_pkg::PRE_W'(DIV_SLOW - 1);
  logic [wdog_pkg::PRE_W-1:0] pre_cnt_r;
  logic [wdog_pkg::PRE_W-1:0] pre_cnt_nxt;
  logic [wdog_pkg::PRE_W-1:0] last;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    last = div_sel_in ? LAST_SLOW : LAST_FAST;
    tick_out = !clear_in && (pre_cnt_r >= last);
    pre_cnt_nxt = pre_cnt_r + 7'h01;
    // a switch to the fast divisor mid-count just wraps early, never stalls
    if (clear_in || tick_out) begin
      pre_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end
endmodule

// *** rtl/wdog_reset_source.sv ***
// module: watchdog timer with reset-source flags and internal reset sequencing
`timescale 1ns/1ps
module wdog_reset_source (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [wdog_pkg::ADDR_W-1:0] addr_in,
  input wire logic [wdog_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [wdog_pkg::DATA_W-1:0] rdata_out,
  input wire logic reset_in_n_in,
  input wire logic reset_mode_pin_in,
  output logic reset_out_n_out,
  output logic chip_reset_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [wdog_pkg::SEQ_W-1:0] MIN_LAST = wdog_pkg::SEQ_W'(wdog_pkg::MIN_PULSE_CYC - 1);
  localparam logic [wdog_pkg::SEQ_W-1:0] LONG_LAST = wdog_pkg::SEQ_W'(wdog_pkg::LONG_SEQ_CYC - 1);
  localparam logic [wdog_pkg::SEQ_W-1:0] WD_LAST = wdog_pkg::SEQ_W'(wdog_pkg::WD_SEQ_CYC - 1);
  localparam logic [wdog_pkg::CNT_W-1:0] CNT_MAX = '1;
  // the reset hold is checked in two plain delays, the second one 300 cycles
  localparam int WD_GAP = wdog_pkg::WD_SEQ_CYC - 301;

  logic pin_meta_r, pin_sync_r, mode_meta_r, mode_sync_r;
  wdog_pkg::rst_state_e st_r, st_nxt;
  logic [wdog_pkg::SEQ_W-1:0] seq_r, seq_nxt;
  logic [wdog_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [wdog_pkg::RELOAD_W-1:0] reload_r, reload_nxt;
  logic psel_r, psel_nxt;
  logic en_r, en_nxt;
  logic end_of_init_instruction_r, end_of_init_instruction_nxt;
  wdog_pkg::reset_flags_s flags_r, flags_nxt;
  logic [wdog_pkg::IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev;
  logic [wdog_pkg::DATA_W-1:0] rdata_nxt;
  logic rst_out_n_nxt, chip_rst_nxt, irq_nxt;
  logic tick, run, ovf, wr_ctrl, wr_cmd, cmd_svc, cmd_dis, cmd_end_of_init_instruction, cmd_swrst, pin_low;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      mode_meta_r <= 1'b1;
      mode_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= reset_in_n_in;
      pin_sync_r <= pin_meta_r;
      mode_meta_r <= reset_mode_pin_in;
      mode_sync_r <= mode_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  wdog_prescaler #(
    .DIV_FAST(wdog_pkg::DIV_FAST),
    .DIV_SLOW(wdog_pkg::DIV_SLOW)
  ) u_pre (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .clear_in(!run),
    .div_sel_in(psel_r),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    run = (st_r == wdog_pkg::ST_RUN);
    pin_low = !pin_sync_r;
    wr_ctrl = run && wr_in && (addr_in == wdog_pkg::OFS_CTRL);
    wr_cmd = run && wr_in && (addr_in == wdog_pkg::OFS_CMD);
    cmd_svc = wr_cmd && wdata_in[wdog_pkg::CMD_SERVICE_BIT];
    cmd_dis = wr_cmd && wdata_in[wdog_pkg::CMD_DISABLE_BIT];
    cmd_end_of_init_instruction = wr_cmd && wdata_in[wdog_pkg::CMD_END_OF_INIT_INSTRUCTION_BIT];
    cmd_swrst = wr_cmd && wdata_in[wdog_pkg::CMD_SWRST_BIT];
    // a service in the overflow cycle wins, so a late service still saves the chip
    ovf = run && en_r && tick && !cmd_svc && (cnt_r == CNT_MAX);
  end

  // ----------------------------------------------------------------
  // reset sequencer and watchdog state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    reload_nxt = reload_r;
    psel_nxt = psel_r;
    en_nxt = en_r;
    end_of_init_instruction_nxt = end_of_init_instruction_r;
    flags_nxt = flags_r;
    ev = '0;
    case (st_r)
      wdog_pkg::ST_RUN: begin
        if (pin_low && !mode_sync_r) begin
          // asynchronous hardware reset: no flag names it, old cause is dropped
          st_nxt = wdog_pkg::ST_HOLD;
          flags_nxt = wdog_pkg::FLAGS_NONE;
        end else if (pin_low) begin
          seq_nxt = seq_r + 11'h001;
          if (seq_r == MIN_LAST) begin
            st_nxt = wdog_pkg::ST_HW_SEQ;
            seq_nxt = '0;
          end
        end else begin
          seq_nxt = '0;
        end
        if (cmd_swrst) begin
          st_nxt = wdog_pkg::ST_WD_SEQ;
          seq_nxt = '0;
          flags_nxt = wdog_pkg::FLAGS_NONE;
          flags_nxt.sw_reset_flag = 1'b1;
        end else if (ovf) begin
          st_nxt = wdog_pkg::ST_WD_SEQ;
          seq_nxt = '0;
          flags_nxt = wdog_pkg::FLAGS_NONE;
          flags_nxt.wdog_reset_flag = 1'b1;
          ev[wdog_pkg::IRQ_OVF_BIT] = 1'b1;
        end else begin
          if (wr_ctrl) begin
            psel_nxt = wdata_in[wdog_pkg::CTRL_PSEL_BIT];
            reload_nxt = wdata_in[wdog_pkg::CTRL_RELOAD_LSB +: wdog_pkg::RELOAD_W];
          end
          if (cmd_svc) begin
            cnt_nxt = {reload_r, 8'h00};
          end else if (en_r && tick) begin
            cnt_nxt = cnt_r + 16'h0001;
          end
          if (cmd_dis && !end_of_init_instruction_r) begin
            en_nxt = 1'b0;
          end else if (cmd_dis) begin
            ev[wdog_pkg::IRQ_REFUSED_BIT] = 1'b1;
          end
          if (cmd_end_of_init_instruction) begin
            end_of_init_instruction_nxt = 1'b1;
            flags_nxt = wdog_pkg::FLAGS_NONE;
          end
        end
      end
      wdog_pkg::ST_HW_SEQ: begin
        seq_nxt = seq_r + 11'h001;
        if (seq_r == LONG_LAST) begin
          // sample the pin once the sequence ends
          flags_nxt = wdog_pkg::FLAGS_NONE;
          flags_nxt.short_hw_reset_flag = 1'b1;
          flags_nxt.long_hw_reset_flag = pin_low;
          st_nxt = pin_low ? wdog_pkg::ST_HOLD : wdog_pkg::ST_RUN;
          ev[wdog_pkg::IRQ_HWRST_BIT] = 1'b1;
        end
      end
      wdog_pkg::ST_HOLD: begin
        seq_nxt = '0;
        if (!pin_low) begin
          st_nxt = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_WD_SEQ: begin
        seq_nxt = seq_r + 11'h001;
        if (seq_r == WD_LAST) begin
          st_nxt = wdog_pkg::ST_RUN;
          seq_nxt = '0;
        end
      end
      default: begin
        st_nxt = wdog_pkg::ST_RUN;
        seq_nxt = '0;
      end
    endcase
    if (!run) begin
      // internal reset state: watchdog restarts enabled from zero
      cnt_nxt = '0;
      reload_nxt = '0;
      psel_nxt = 1'b0;
      en_nxt = 1'b1;
      end_of_init_instruction_nxt = 1'b0;
    end
    rst_out_n_nxt = (st_nxt == wdog_pkg::ST_RUN);
    chip_rst_nxt = (st_nxt != wdog_pkg::ST_RUN);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= wdog_pkg::ST_RUN;
      seq_r <= '0;
      cnt_r <= '0;
      reload_r <= '0;
      psel_r <= 1'b0;
      en_r <= 1'b1;
      end_of_init_instruction_r <= 1'b0;
      flags_r <= wdog_pkg::FLAGS_POR;
      reset_out_n_out <= 1'b0;
      chip_reset_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
      reload_r <= reload_nxt;
      psel_r <= psel_nxt;
      en_r <= en_nxt;
      end_of_init_instruction_r <= end_of_init_instruction_nxt;
      flags_r <= flags_nxt;
      reset_out_n_out <= rst_out_n_nxt;
      chip_reset_out <= chip_rst_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  always_comb begin
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    // interrupt registers survive the internal reset, only the async reset clears them
    if (wr_in && addr_in == wdog_pkg::OFS_IRQ_MASK) begin
      imask_nxt = wdata_in[wdog_pkg::IRQ_W-1:0];
    end
    if (wr_in && addr_in == wdog_pkg::OFS_IRQ_STAT) begin
      istat_nxt = istat_r & ~wdata_in[wdog_pkg::IRQ_W-1:0];
    end
    istat_nxt = istat_nxt | ev;
    irq_nxt = |(istat_nxt & imask_nxt);
    rdata_nxt = '0;
    if (rd_in) begin
      case (addr_in)
        wdog_pkg::OFS_CTRL: begin
          rdata_nxt[wdog_pkg::CTRL_PSEL_BIT] = psel_r;
          rdata_nxt[wdog_pkg::CTRL_EN_BIT] = en_r;
          rdata_nxt[wdog_pkg::CTRL_FLAGS_LSB +: 5] = flags_r;
          rdata_nxt[wdog_pkg::CTRL_END_OF_INIT_INSTRUCTION_BIT] = end_of_init_instruction_r;
          rdata_nxt[wdog_pkg::CTRL_RELOAD_LSB +: wdog_pkg::RELOAD_W] = reload_r;
        end
        wdog_pkg::OFS_COUNT: begin
          rdata_nxt[wdog_pkg::CNT_W-1:0] = cnt_r;
        end
        wdog_pkg::OFS_IRQ_STAT: begin
          rdata_nxt[wdog_pkg::IRQ_W-1:0] = istat_r;
        end
        wdog_pkg::OFS_IRQ_MASK: begin
          rdata_nxt[wdog_pkg::IRQ_W-1:0] = imask_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      imask_r <= '0;
      istat_r <= '0;
      irq_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      irq_out <= irq_nxt;
      rdata_out <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  property p_enabled_after_reset;
    $fell(chip_reset_out) |-> en_r && !end_of_init_instruction_r && cnt_r == '0;
  endproperty
  a_enabled_after_reset: assert property (p_enabled_after_reset) else $error("watchdog not enabled after reset");

  property p_disable_refused;
    cmd_dis && end_of_init_instruction_r && run |=> en_r == $past(en_r);
  endproperty
  a_disable_refused: assert property (p_disable_refused) else $error("disable accepted after end of init");

  property p_ovf_resets;
    ovf |=> (chip_reset_out && !reset_out_n_out) [*8];
  endproperty
  a_ovf_resets: assert property (p_ovf_resets) else $error("overflow did not reset chip");

  property p_wd_seq_len;
    ovf |=> ##WD_GAP !reset_out_n_out ##300 !reset_out_n_out ##1 (reset_out_n_out && !chip_reset_out);
  endproperty
  a_wd_seq_len: assert property (p_wd_seq_len) else $error("watchdog reset length wrong");

  property p_ovf_flag;
    ovf |=> flags_r.wdog_reset_flag && !flags_r.power_on_flag && istat_r[wdog_pkg::IRQ_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("watchdog flag not set");

  property p_end_of_init_instruction_clears;
    cmd_end_of_init_instruction && !cmd_swrst && !ovf |=> flags_r == wdog_pkg::FLAGS_NONE && end_of_init_instruction_r;
  endproperty
  a_end_of_init_instruction_clears: assert property (p_end_of_init_instruction_clears) else $error("end of init left flags set");

  property p_count_step;
    run && en_r && tick && !cmd_svc && !cmd_swrst && !ovf |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance on tick");

  property p_div2;
    run && !psel_r && tick && !$past(psel_r) ##1 run && !psel_r |-> !tick ##1 (tick || !run || psel_r);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two spacing wrong");

  property p_service;
    cmd_svc && !cmd_swrst |=> cnt_r == {$past(reload_r), 8'h00};
  endproperty
  a_service: assert property (p_service) else $error("service load wrong");

  property p_long_flag;
    st_r == wdog_pkg::ST_HW_SEQ && seq_r == LONG_LAST && pin_low |=> flags_r.long_hw_reset_flag && flags_r.short_hw_reset_flag;
  endproperty
  a_long_flag: assert property (p_long_flag) else $error("long reset not flagged");

  property p_short_only;
    st_r == wdog_pkg::ST_HW_SEQ && seq_r == LONG_LAST && !pin_low |=> !flags_r.long_hw_reset_flag && !chip_reset_out;
  endproperty
  a_short_only: assert property (p_short_only) else $error("short reset misflagged");

  c_overflow: cover property (ovf);
  c_long_reset: cover property (st_r == wdog_pkg::ST_HW_SEQ ##1 flags_r.long_hw_reset_flag);
  c_refused: cover property (cmd_dis && end_of_init_instruction_r && run);
  c_sw_reset: cover property (cmd_swrst ##1 chip_reset_out);
endmodule

// *** test/wdog_reset_source_tb_top.sv ***
// testbench: random and directed checks of the watchdog and reset-source block
`timescale 1ns/1ps
module wdog_reset_source_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [wdog_pkg::ADDR_W-1:0] addr_in = '0;
  logic [wdog_pkg::DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic reset_in_n_in = 1'b1;
  logic reset_mode_pin_in = 1'b1;
  logic [wdog_pkg::DATA_W-1:0] rdata_out;
  logic reset_out_n_out;
  logic chip_reset_out;
  logic irq_out;
  int num_errors = 0;
  int check_count = 0;
  int n;
  logic s;
  logic [31:0] seed = 32'd50259;
  logic [31:0] d;
  logic [31:0] e;
  logic [7:0] r;
  localparam logic [7:0] a_ctrl = wdog_pkg::OFS_CTRL;
  localparam logic [7:0] a_cmd = wdog_pkg::OFS_CMD;
  localparam logic [7:0] a_cnt = wdog_pkg::OFS_COUNT;
  localparam logic [7:0] a_stat = wdog_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] a_mask = wdog_pkg::OFS_IRQ_MASK;

  always #4 clk_sys_in = ~clk_sys_in;

  wdog_reset_source DUT (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .reset_in_n_in(reset_in_n_in),
    .reset_mode_pin_in(reset_mode_pin_in),
    .reset_out_n_out(reset_out_n_out),
    .chip_reset_out(chip_reset_out),
    .irq_out(irq_out)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // flags in order power-on, long, short, watchdog, software
  function automatic logic [31:0] ctrl_exp(input logic [7:0] rel, input logic psel, input logic en,
                                           input logic ei, input logic [4:0] fl);
    return {16'h0000, rel, ei, fl, en, psel};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  // bounded wait for the internal reset to reach a level
  task automatic wait_for(input logic lvl, input int lim, output int k);
    k = 0;
    while (chip_reset_out !== lvl && k < lim) begin
      @(posedge clk_sys_in);
      #1;
      k = k + 1;
    end
    // a limit that runs out is a mismatch of its own
    if (chip_reset_out !== lvl) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t internal reset did not reach the awaited level", $time);
    end
  endtask

  // pulse the reset pin low for len+1 cycles, then wait out the sequence
  task automatic hw(input logic mode, input int len, output logic seen);
    seen = 1'b0;
    @(posedge clk_sys_in);
    reset_mode_pin_in <= mode;
    reset_in_n_in <= 1'b0;
    repeat (len) begin
      @(posedge clk_sys_in);
      #1;
      seen = seen | chip_reset_out;
    end
    @(posedge clk_sys_in);
    reset_in_n_in <= 1'b1;
    reset_mode_pin_in <= 1'b1;
    wait_for(1'b0, 1500, n);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: whole run is near 3900 cycles, so 200 us is ample
  // ----------------------------------------------------------------
  initial begin
    #200000;
    num_errors = num_errors + 1;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b10000), "ctrl after power-on");
    rd(8'h3c, d);
    check(d, 32'h0, "unmapped read");
    repeat (6) begin
      seed = xs(seed);
      r = seed[7:0];
      wr(a_ctrl, {16'h0000, r, 7'h00, seed[8]});
      rd(a_ctrl, d);
      check(d, ctrl_exp(r, seed[8], 1'b1, 1'b0, 5'b10000), "ctrl readback");
      wr(a_cmd, 32'h1);
      rd(a_cnt, d);
      check({d[15:8], d[7:1]}, {r, 7'h00}, "count after service");
    end
    // tick rate for both prescale selects; tolerance covers prescaler phase
    wr(a_ctrl, 32'h0);
    wr(a_cmd, 32'h1);
    cycles(200);
    rd(a_cnt, d);
    check(d[15:0] >= 16'd98 && d[15:0] <= 16'd103, 1'b1, "fast tick rate");
    wr(a_ctrl, 32'h1);
    wr(a_cmd, 32'h1);
    cycles(300);
    rd(a_cnt, d);
    check(d[15:0] >= 16'd2 && d[15:0] <= 16'd3, 1'b1, "slow tick rate");
    // shortest timeout: 256 ticks of 2 cycles
    wr(a_ctrl, 32'h0000_ff00);
    wr(a_cmd, 32'h1);
    wait_for(1'b1, 700, n);
    check(n >= 505 && n <= 520, 1'b1, "overflow timing");
    check(reset_out_n_out, 1'b0, "reset pin low on overflow");
    wait_for(1'b0, 700, n);
    check(n >= 508 && n <= 516, 1'b1, "watchdog reset length");
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b00010), "flags after overflow");
    rd(a_stat, d);
    check(d, 32'h1, "overflow status");
    check(irq_out, 1'b0, "masked interrupt");
    wr(a_mask, 32'h1);
    cycles(2);
    check(irq_out, 1'b1, "unmasked interrupt");
    wr(a_stat, 32'h1);
    cycles(2);
    check(irq_out, 1'b0, "interrupt cleared");
    wr(a_mask, 32'h0);
    // end of init clears flags and locks the enable
    wr(a_cmd, 32'h4);
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b1, 5'b00000), "flags cleared");
    wr(a_cmd, 32'h2);
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b1, 5'b00000), "late disable refused");
    rd(a_stat, d);
    check(d, 32'h2, "refused disable status");
    // software reset, then an early disable that must take effect
    wr(a_cmd, 32'h8);
    wait_for(1'b1, 4, n);
    check(chip_reset_out, 1'b1, "software reset");
    wait_for(1'b0, 700, n);
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b00001), "flags after software reset");
    wr(a_cmd, 32'h2);
    rd(a_cnt, d);
    cycles(40);
    rd(a_cnt, e);
    check(e, d, "disabled counter holds");
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b0, 1'b0, 5'b00001), "early disable taken");
    wr(a_stat, 32'h7);
    // reset pin: spike, short, long and asynchronous pulses
    hw(1'b1, 30, s);
    check(s, 1'b0, "spike ignored");
    hw(1'b1, 100, s);
    check(s, 1'b1, "short pulse resets");
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b00100), "short flag only");
    rd(a_stat, d);
    check(d, 32'h4, "sampling status");
    hw(1'b1, 1000, s);
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b01100), "long and short flags");
    hw(1'b0, 20, s);
    check(s, 1'b1, "asynchronous reset");
    rd(a_ctrl, d);
    check(d, ctrl_exp(8'h00, 1'b0, 1'b1, 1'b0, 5'b00000), "flags after async reset");
    results();
  end
endmodule
